/* hdl/arc_defines.svh */
// constants for the auto-reclose sequencer: bus map, fields, reset values, timing
// assumes a 100 MHz clock and a millisecond time base
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH

`define ARC_CLK_PERIOD_NS 10
`define ARC_TICK_PERIOD_NS 1000000
`define ARC_TICK_CYCLES (`ARC_TICK_PERIOD_NS / `ARC_CLK_PERIOD_NS)

`define ARC_TW 20
`define ARC_ADDR_CTRL 8'h00
`define ARC_ADDR_TIME0 8'h04
`define ARC_ADDR_STATUS 8'h34
`define ARC_NUM_TIMES 12

`define ARC_F_OP 0
`define ARC_F_CYC_HI 3
`define ARC_F_CYC_LO 1
`define ARC_F_START_SRC 4
`define ARC_F_EVO 5
`define ARC_F_MON 6
`define ARC_F_3PH_DIS 7
`define ARC_F_ACC_HI 11
`define ARC_F_ACC_LO 8
`define ARC_CTRL_RESET 12'h003

`define ARC_T_RECLAIM 0
`define ARC_T_CLOSE 1
`define ARC_T_DYN 2
`define ARC_T_MC 3
`define ARC_T_ACTION 4
`define ARC_T_START_MAX 5
`define ARC_T_DT_DELAY 6
`define ARC_T_CB_WAIT 7
`define ARC_T_SYNC 8
`define ARC_T_SWITCH 9
`define ARC_T_DEAD_1PH 10
`define ARC_T_DEAD_3PH 11

`define ARC_RST_RECLAIM 20'h0_07d0
`define ARC_RST_CLOSE 20'h0_0064
`define ARC_RST_DYN 20'h0_05dc
`define ARC_RST_1000 20'h0_03e8
`define ARC_RST_DT_DELAY 20'h0_0bb8
`define ARC_RST_10000 20'h0_2710
`define ARC_RST_DEAD_3PH 20'h0_01f4

`define ARC_IN_CB_READY 0
`define ARC_IN_SYNC_REL 1
`define ARC_IN_PROT_START 2
`define ARC_IN_MAN_CLOSE 3
`define ARC_IN_CB_OPEN 4
`define ARC_IN_TRIP 5
`define ARC_IN_3PH 6
`define ARC_IN_DT_DELAY 7
`define ARC_IN_GEN_BLOCK 8
`define ARC_IN_SW_DONE 9
`define ARC_NUM_IN 10

`endif

/* hdl/arc_pkg.sv */
// types for the auto-reclose sequencer
// assumes nothing beyond the compile order
package arc_pkg;
  typedef enum logic [9:0] {
    st_idle = 10'h001,
    st_start = 10'h002,
    st_delay = 10'h004,
    st_dead = 10'h008,
    st_cbwait = 10'h010,
    st_sync = 10'h020,
    st_switch = 10'h040,
    st_close = 10'h080,
    st_dyn = 10'h100,
    st_reclaim = 10'h200
  } arc_state_type;
endpackage : arc_pkg

/* hdl/arc_ms_tick.sv */
// millisecond tick generator
// assumes one free-running system clock
`timescale 1ns/100ps
module arc_ms_tick #(
  parameter int TICK_CYCLES = 100000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (count == 32'(TICK_CYCLES - 1)) begin
      count <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule : arc_ms_tick

/* hdl/arc_timer.sv */
// millisecond timer: start restarts from zero, expired holds until stop or restart
// assumes tick is a one-cycle pulse from the same clock
`timescale 1ns/100ps
`include "arc_defines.svh"
module arc_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [`ARC_TW-1:0] limit,
  output logic running,
  output logic expired
);
  logic [`ARC_TW-1:0] count;

  // a zero setting expires at once
  assign expired = running && (count >= limit);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      running <= 1'b0;
    end else if (start) begin
      count <= '0;
      running <= 1'b1;
    end else if (stop) begin
      running <= 1'b0;
    end else if (running && tick && !expired) begin
      count <= count + `ARC_TW'(1);
    end
  end
endmodule : arc_timer

/* hdl/arc_sequencer.sv */
// auto-reclose sequencer: breaker, synchro and close control with APB settings
// assumes a 100 MHz clock; protection and breaker inputs arrive asynchronously
//
// What this block does
// - at dead time end close only once breaker-ready is true; else keep waiting
// - breaker-ready absent past the supervision time enters dynamic blocked
// - closing needs synchro release, awaited at most the synchro-check time
// - synchro wait expiry starts synchronous switching, raises its request and second timer
// - no switching before that timer expires: dynamic blocked, then reset
// - one close output for all phases, pulse the close command time to within one tick
// - close starts reclaim; reclaim never ends before the close pulse ends
// - fault in reclaim: next cycle; expiry: success; later fault: restart at cycle one
// - protection start during reclaim keeps the sequence alive for a late trip
// - manual close holds not-ready for the post-manual-close block time
// - manual close during a running cycle forces dynamic blocked and reset
// - evolving fault: block with final trip, or continue with three-phase timing
// - fault persisting after the last enabled cycle: final trip, then dynamic blocked
// - fault again in dead time after a multi-phase fault raises final trip
// - protection start runs the action timer; no trip before expiry blocks
// - enabled acceleration asserts trip acceleration at first start or dead time end
// - dynamic blocked runs its timer; no close while it runs
// - further dynamic block causes: long start, long delay, blocked start, open, 3ph
// - dynamic blocks act while running, and from idle on a blocked trip or action timeout; not-ready only while idle
// - not-ready causes: off, no cycles, breaker not ready, manual close, open, block
// - blocked output shows dynamic blocked or not-ready
// - up to four cycles, count selected from disabled to four; settings five to seven never reach a last cycle
// - start on trip reset or on breaker open, by setting
`timescale 1ns/100ps
`include "arc_defines.svh"
module arc_sequencer #(
  parameter int TICK_CYCLES = `ARC_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic breaker_ready_in,
  input wire logic sync_release_in,
  input wire logic protection_start_in,
  input wire logic manual_close_in,
  input wire logic breaker_open_in,
  input wire logic reclose_start_in,
  input wire logic three_phase_trip_in,
  input wire logic dead_time_delay_in,
  input wire logic general_block_in,
  input wire logic sync_switch_done_in,
  output logic close_cmd_out,
  output logic sync_switch_close_req,
  output logic final_trip_out,
  output logic trip_accel_out,
  output logic blocked_out,
  output logic in_progress_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [11:0] ctrl;
  logic [`ARC_TW-1:0] times [`ARC_NUM_TIMES];
  logic [31:0] status;
  logic wr_en;
  logic addr_time;
  logic [3:0] tidx;

  assign tidx = paddr[5:2] - 4'h1;
  assign addr_time = (paddr[1:0] == 2'b00) && (paddr >= `ARC_ADDR_TIME0) && (paddr < `ARC_ADDR_STATUS);
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(addr_time || paddr == `ARC_ADDR_CTRL || (paddr == `ARC_ADDR_STATUS && !pwrite));

  logic operation_enable;
  logic [2:0] cycle_count_select;
  logic start_source_select;
  logic evolving_fault_mode;
  logic breaker_state_monitor_en;
  logic three_phase_reclose_disable;
  logic [3:0] accel_en;
  assign operation_enable = ctrl[`ARC_F_OP];
  assign cycle_count_select = ctrl[`ARC_F_CYC_HI:`ARC_F_CYC_LO];
  assign start_source_select = ctrl[`ARC_F_START_SRC];
  assign evolving_fault_mode = ctrl[`ARC_F_EVO];
  assign breaker_state_monitor_en = ctrl[`ARC_F_MON];
  assign three_phase_reclose_disable = ctrl[`ARC_F_3PH_DIS];
  assign accel_en = ctrl[`ARC_F_ACC_HI:`ARC_F_ACC_LO];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `ARC_CTRL_RESET;
    end else if (wr_en && paddr == `ARC_ADDR_CTRL) begin
      ctrl <= pwdata[11:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      times[`ARC_T_RECLAIM] <= `ARC_RST_RECLAIM;
      times[`ARC_T_CLOSE] <= `ARC_RST_CLOSE;
      times[`ARC_T_DYN] <= `ARC_RST_DYN;
      times[`ARC_T_MC] <= `ARC_RST_1000;
      times[`ARC_T_ACTION] <= `ARC_RST_1000;
      times[`ARC_T_START_MAX] <= `ARC_RST_1000;
      times[`ARC_T_DT_DELAY] <= `ARC_RST_DT_DELAY;
      times[`ARC_T_CB_WAIT] <= `ARC_RST_1000;
      times[`ARC_T_SYNC] <= `ARC_RST_10000;
      times[`ARC_T_SWITCH] <= `ARC_RST_10000;
      times[`ARC_T_DEAD_1PH] <= `ARC_RST_1000;
      times[`ARC_T_DEAD_3PH] <= `ARC_RST_DEAD_3PH;
    end else if (wr_en && addr_time) begin
      times[tidx] <= pwdata[`ARC_TW-1:0];
    end
  end

  // read data captured in the setup phase so the access phase needs no wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `ARC_ADDR_CTRL) prdata <= {20'h0_0000, ctrl};
      else if (addr_time) prdata <= {12'h000, times[tidx]};
      else if (paddr == `ARC_ADDR_STATUS) prdata <= status;
      else prdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edges
  logic [`ARC_NUM_IN-1:0] pins, sync1, sync2, prev, rise;
  assign pins = {sync_switch_done_in, general_block_in, dead_time_delay_in, three_phase_trip_in,
                 reclose_start_in, breaker_open_in, manual_close_in, protection_start_in,
                 sync_release_in, breaker_ready_in};

  genvar gi;
  generate
    for (gi = 0; gi < `ARC_NUM_IN; gi++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          prev[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
          prev[gi] <= sync2[gi];
        end
      end
    end
  endgenerate
  assign rise = sync2 & ~prev;

  logic cb_ready, sync_rel, cb_open, trip, ph3, dt_delay, gen_block, sw_done;
  logic trip_rise, prot_rise, man_rise, open_rise, ph3_rise;
  assign cb_ready = sync2[`ARC_IN_CB_READY];
  assign sync_rel = sync2[`ARC_IN_SYNC_REL];
  assign cb_open = sync2[`ARC_IN_CB_OPEN];
  assign trip = sync2[`ARC_IN_TRIP];
  assign ph3 = sync2[`ARC_IN_3PH];
  assign dt_delay = sync2[`ARC_IN_DT_DELAY];
  assign gen_block = sync2[`ARC_IN_GEN_BLOCK];
  assign sw_done = sync2[`ARC_IN_SW_DONE];
  assign trip_rise = rise[`ARC_IN_TRIP];
  assign prot_rise = rise[`ARC_IN_PROT_START];
  assign man_rise = rise[`ARC_IN_MAN_CLOSE];
  assign open_rise = rise[`ARC_IN_CB_OPEN];
  assign ph3_rise = rise[`ARC_IN_3PH];

  ////////////////////////////////////////////////////////////////////////////////
  // timers on a common millisecond tick
  arc_pkg::arc_state_type state, next_state;
  logic tick;
  logic seq_exp, rec_run, rec_exp, act_exp, mc_run, mc_exp;
  logic [`ARC_TW-1:0] seq_limit;
  logic running, three_ph, held;

  arc_ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (.clk(clk), .rst(rst), .tick(tick));

  always_comb begin
    case (state)
      arc_pkg::st_start: seq_limit = times[`ARC_T_START_MAX];
      arc_pkg::st_delay: seq_limit = times[`ARC_T_DT_DELAY];
      arc_pkg::st_dead: seq_limit = three_ph ? times[`ARC_T_DEAD_3PH] : times[`ARC_T_DEAD_1PH];
      arc_pkg::st_cbwait: seq_limit = times[`ARC_T_CB_WAIT];
      arc_pkg::st_sync: seq_limit = times[`ARC_T_SYNC];
      arc_pkg::st_switch: seq_limit = times[`ARC_T_SWITCH];
      arc_pkg::st_close: seq_limit = times[`ARC_T_CLOSE];
      arc_pkg::st_dyn: seq_limit = times[`ARC_T_DYN];
      default: seq_limit = '0;
    endcase
  end

  arc_timer u_seq (.clk(clk), .rst(rst), .tick(tick), .start(next_state != state), .stop(1'b0),
                   .limit(seq_limit), .running(), .expired(seq_exp));
  // reclaim starts with the close command
  arc_timer u_rec (.clk(clk), .rst(rst), .tick(tick),
                   .start(next_state == arc_pkg::st_close && state != arc_pkg::st_close),
                   .stop(!running), .limit(times[`ARC_T_RECLAIM]), .running(rec_run), .expired(rec_exp));
  arc_timer u_act (.clk(clk), .rst(rst), .tick(tick), .start(prot_rise && state != arc_pkg::st_dyn),
                   .stop(trip_rise || state == arc_pkg::st_dyn), .limit(times[`ARC_T_ACTION]), .running(),
                   .expired(act_exp));
  arc_timer u_mc (.clk(clk), .rst(rst), .tick(tick), .start(man_rise), .stop(mc_exp),
                  .limit(times[`ARC_T_MC]), .running(mc_run), .expired(mc_exp));

  ////////////////////////////////////////////////////////////////////////////////
  // sequence
  logic [1:0] cycle;
  logic last_cycle, not_ready, fin_evt, advance, restart;
  assign running = !(state == arc_pkg::st_idle || state == arc_pkg::st_dyn);
  assign last_cycle = ({1'b0, cycle} + 3'h1) >= cycle_count_select;
  assign not_ready = !operation_enable || cycle_count_select == 3'h0 || !cb_ready || mc_run
                     || (breaker_state_monitor_en && cb_open) || (start_source_select && cb_open) || gen_block;

  always_comb begin
    next_state = state;
    fin_evt = 1'b0;
    advance = 1'b0;
    restart = 1'b0;
    case (state)
      arc_pkg::st_idle: begin
        if (trip_rise && operation_enable && cycle_count_select != 3'h0) begin
          if (mc_run || gen_block || (ph3 && three_phase_reclose_disable)) next_state = arc_pkg::st_dyn;
          else begin
            next_state = arc_pkg::st_start;
            restart = 1'b1;
          end
        end
      end
      arc_pkg::st_start: begin
        if (start_source_select ? cb_open : !trip) next_state = arc_pkg::st_delay;
        else if (seq_exp) next_state = arc_pkg::st_dyn;
      end
      arc_pkg::st_delay: begin
        if (!dt_delay) next_state = arc_pkg::st_dead;
        else if (seq_exp) next_state = arc_pkg::st_dyn;
      end
      arc_pkg::st_dead: begin
        if (trip_rise && three_ph) fin_evt = 1'b1;
        else if (ph3_rise && !evolving_fault_mode) fin_evt = 1'b1;
        else if (seq_exp) next_state = arc_pkg::st_cbwait;
      end
      arc_pkg::st_cbwait: begin
        if (cb_ready) next_state = arc_pkg::st_sync;
        else if (seq_exp) next_state = arc_pkg::st_dyn;
      end
      arc_pkg::st_sync: begin
        if (sync_rel) next_state = arc_pkg::st_close;
        else if (seq_exp) next_state = arc_pkg::st_switch;
      end
      arc_pkg::st_switch: begin
        if (sw_done) next_state = arc_pkg::st_close;
        else if (seq_exp) next_state = arc_pkg::st_dyn;
      end
      arc_pkg::st_close: begin
        // reclaim is judged only after the pulse, so a long pulse stretches it
        if (seq_exp) next_state = arc_pkg::st_reclaim;
      end
      arc_pkg::st_reclaim: begin
        if (trip_rise) begin
          if (last_cycle) fin_evt = 1'b1;
          else begin
            next_state = arc_pkg::st_start;
            advance = 1'b1;
          end
        end else if (rec_exp && !held) next_state = arc_pkg::st_idle;
      end
      default: begin
        if (seq_exp) next_state = arc_pkg::st_idle;
      end
    endcase
    if (running && man_rise) next_state = arc_pkg::st_dyn;
    else if (running && breaker_state_monitor_en && open_rise && !trip) next_state = arc_pkg::st_dyn;
    else if (act_exp && state != arc_pkg::st_dyn) next_state = arc_pkg::st_dyn;
    if (fin_evt) next_state = arc_pkg::st_dyn;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= arc_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycle <= 2'h0;
    end else if (restart) begin
      cycle <= 2'h0;
    end else if (advance) begin
      cycle <= cycle + 2'h1;
    end
  end

  // once three-phase timing is used it stays for the rest of the sequence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      three_ph <= 1'b0;
    end else if (restart) begin
      three_ph <= ph3;
    end else if (running && ph3) begin
      three_ph <= 1'b1;
    end
  end

  // a start seen around the close keeps the sequence waiting for a late trip
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held <= 1'b0;
    end else if ((state == arc_pkg::st_close || state == arc_pkg::st_reclaim) && prot_rise) begin
      held <= 1'b1;
    end else if (state != arc_pkg::st_close && state != arc_pkg::st_reclaim) begin
      held <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  logic [1:0] acc_idx;
  logic accel_set;
  assign acc_idx = running ? cycle : 2'h0;
  assign accel_set = (prot_rise && accel_en[acc_idx])
                     || (state == arc_pkg::st_dead && next_state == arc_pkg::st_cbwait && accel_en[cycle]);
  assign status = {20'h0_0000, cycle, state};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      close_cmd_out <= 1'b0;
      sync_switch_close_req <= 1'b0;
      in_progress_out <= 1'b0;
    end else begin
      close_cmd_out <= next_state == arc_pkg::st_close;
      sync_switch_close_req <= next_state == arc_pkg::st_switch;
      in_progress_out <= next_state != arc_pkg::st_idle && next_state != arc_pkg::st_dyn;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      final_trip_out <= 1'b0;
    end else if (fin_evt) begin
      final_trip_out <= 1'b1;
    end else if (state == arc_pkg::st_idle) begin
      final_trip_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trip_accel_out <= 1'b0;
    end else if (accel_set) begin
      trip_accel_out <= 1'b1;
    end else if (trip_rise || (next_state != state && (next_state == arc_pkg::st_idle
                                                      || next_state == arc_pkg::st_dyn))) begin
      trip_accel_out <= 1'b0;
    end
  end

  // not-ready only counts while idle, dynamic blocking from a running cycle or a blocked trip or action timeout in idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blocked_out <= 1'b0;
    end else begin
      blocked_out <= state == arc_pkg::st_dyn || (!running && not_ready);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_close_matches_state: assert property (@(posedge clk) disable iff (rst)
    close_cmd_out == (state == arc_pkg::st_close)) else $error("close output out of step with state");
  a_no_close_blocked: assert property (@(posedge clk) disable iff (rst)
    state == arc_pkg::st_dyn |-> !close_cmd_out) else $error("close issued while dynamically blocked");
  a_wait_breaker_ready: assert property (@(posedge clk) disable iff (rst)
    state == arc_pkg::st_cbwait && !cb_ready |=> state != arc_pkg::st_sync) else $error("left breaker wait unready");
  a_blocked_shown: assert property (@(posedge clk) disable iff (rst)
    state == arc_pkg::st_dyn |=> blocked_out) else $error("dynamic block not shown");
  a_switch_request: assert property (@(posedge clk) disable iff (rst)
    state == arc_pkg::st_switch |-> sync_switch_close_req) else $error("switching without its request");
  a_final_then_block: assert property (@(posedge clk) disable iff (rst)
    $rose(final_trip_out) |-> state == arc_pkg::st_dyn) else $error("final trip without dynamic block");
  a_manual_blocks: assert property (@(posedge clk) disable iff (rst)
    running && man_rise |=> state == arc_pkg::st_dyn) else $error("manual close did not block the cycle");

  c_success: cover property (@(posedge clk) disable iff (rst)
    state == arc_pkg::st_reclaim ##1 state == arc_pkg::st_idle);
  c_switching: cover property (@(posedge clk) disable iff (rst) state == arc_pkg::st_switch);
  c_final_trip: cover property (@(posedge clk) disable iff (rst) $rose(final_trip_out));
endmodule : arc_sequencer

/* tb/arc_breaker_model.sv */
// breaker and trip side model for the reclose bench
// assumes one clock; the bench steers trip and readiness
`timescale 1ns/100ps
module arc_breaker_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic trip,
  input wire logic close_cmd_out,
  input wire logic ready_en,
  output logic breaker_open_in,
  output logic breaker_ready_in
);
  // poles open on a trip and stay open until a close pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      breaker_open_in <= 1'b0;
    end else if (trip) begin
      breaker_open_in <= 1'b1;
    end else if (close_cmd_out) begin
      breaker_open_in <= 1'b0;
    end
  end
  assign breaker_ready_in = ready_en;
endmodule : arc_breaker_model

/* tb/arc_sequencer_tb.sv */
// self-checking bench for the reclose sequencer over APB
// assumes arc_breaker_model and a ten-cycle millisecond tick
`timescale 1ns/100ps
`include "arc_defines.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module arc_sequencer_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, v, acc;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, x, m;
  logic sync_release_in, protection_start_in, manual_close_in, reclose_start_in, three_phase_trip_in;
  logic dead_time_delay_in, general_block_in, sync_switch_done_in, ready_en, breaker_open_in, breaker_ready_in;
  logic close_cmd_out, sync_switch_close_req, final_trip_out, trip_accel_out, blocked_out, in_progress_out;
  logic [5:0] o;
  logic [31:0] rd_q[$], mk_q[$];
  logic ob_v[$];
  int ob_i[$], cw_q[$];
  int fails = 0, checks_done = 0, cyc = 0, cnt = 0, seed = 34655, dead, k, e;
  logic [19:0] rst_v[12] = '{`ARC_RST_RECLAIM, `ARC_RST_CLOSE, `ARC_RST_DYN, `ARC_RST_1000, `ARC_RST_1000,
    `ARC_RST_1000, `ARC_RST_DT_DELAY, `ARC_RST_1000, `ARC_RST_10000, `ARC_RST_10000, `ARC_RST_1000, `ARC_RST_DEAD_3PH};
  int tv[12] = '{5, 3, 4, 3, 8, 8, 8, 4, 4, 4, 0, 3};
  assign o = {in_progress_out, blocked_out, trip_accel_out, final_trip_out, sync_switch_close_req, close_cmd_out};
  arc_sequencer #(.TICK_CYCLES(10)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .breaker_ready_in(breaker_ready_in), .sync_release_in(sync_release_in), .protection_start_in(protection_start_in),
    .manual_close_in(manual_close_in), .breaker_open_in(breaker_open_in), .reclose_start_in(reclose_start_in),
    .three_phase_trip_in(three_phase_trip_in), .dead_time_delay_in(dead_time_delay_in),
    .general_block_in(general_block_in), .sync_switch_done_in(sync_switch_done_in), .close_cmd_out(close_cmd_out),
    .sync_switch_close_req(sync_switch_close_req), .final_trip_out(final_trip_out), .trip_accel_out(trip_accel_out),
    .blocked_out(blocked_out), .in_progress_out(in_progress_out));
  arc_breaker_model partner (.clk(clk), .rst(rst), .trip(reclose_start_in), .close_cmd_out(close_cmd_out),
    .ready_en(ready_en), .breaker_open_in(breaker_open_in), .breaker_ready_in(breaker_ready_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  // result watcher: register reads, close pulse widths, level checks
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      close_out();
    end
    if (psel && penable && !pwrite && pready === 1'b1 && rd_q.size() > 0) begin
      x = rd_q.pop_front();
      m = mk_q.pop_front();
      `CHK(prdata & m, x)
    end
    if (close_cmd_out === 1'b1) cnt++;
    else if (cnt > 0) begin
      // an unannounced close compares against zero and fails unless it lasts one clock
      e = cw_q.size() > 0 ? cw_q.pop_front() : 0;
      // one millisecond of slack: the pulse starts anywhere within a tick period
      `CHK(cnt > 10 * (e - 1) && cnt <= 10 * e + 1, 1'b1)
      cnt = 0;
    end
  end
  always @(negedge clk) begin
    while (ob_i.size() > 0) begin
      k = ob_i.pop_front();
      v = ob_v.pop_front();
      `CHK(o[k], v)
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task ms(input int n);
    repeat (n * 10) @(posedge clk);
  endtask : ms
  task obs(input int i, input logic b);
    ob_i.push_back(i);
    ob_v.push_back(b);
    @(posedge clk);
  endtask : obs
  task wait_for(input int i, input logic b, input int lim);
    int n;
    n = 0;
    while (o[i] !== b && n < lim) begin
      n++;
      @(posedge clk);
    end
    obs(i, b);
  endtask : wait_for
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    `CHK(pslverr, 1'(a == 8'h80))
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] mk);
    rd_q.push_back(d & mk);
    mk_q.push_back(mk);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task fault(input logic rdy);
    protection_start_in <= 1'b1;
    ms(1);
    obs(3, acc);
    reclose_start_in <= 1'b1;
    ready_en <= rdy;
    ms(2);
    reclose_start_in <= 1'b0;
    protection_start_in <= 1'b0;
  endtask : fault
  task close_out;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, acc} = '0;
    {protection_start_in, manual_close_in, reclose_start_in, three_phase_trip_in} = '0;
    {dead_time_delay_in, general_block_in, sync_switch_done_in} = '0;
    {sync_release_in, ready_en, rst} = 3'b111;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    ms(1);
    rd(`ARC_ADDR_CTRL, 32'h0000_0003, 32'h0000_0fff);
    for (int i = 0; i < 12; i++) rd(8'h04 + 8'(4 * i), {12'h000, rst_v[i]}, 32'h000f_ffff);
    apb(1'b0, 8'h80, 32'h0000_0000);
    dead = 2 + ($random(seed) & 3);
    tv[10] = dead;
    for (int i = 0; i < 12; i++) apb(1'b1, 8'h04 + 8'(4 * i), 32'(tv[i]));
    rd(8'h08, 32'h0000_0003, 32'h000f_ffff);
    // successful reclose with acceleration on for cycle one
    apb(1'b1, `ARC_ADDR_CTRL, 32'h0000_0103);
    acc = 1'b1;
    cw_q.push_back(3);
    fault(1'b1);
    acc = 1'b0;
    wait_for(0, 1'b1, (dead + 4) * 10);
    wait_for(0, 1'b0, 60);
    ms(7);
    obs(5, 1'b0);
    obs(4, 1'b0);
    apb(1'b1, `ARC_ADDR_CTRL, 32'h0000_0003);
    // breaker never ready after the dead time
    fault(1'b0);
    ms(dead + 2);
    obs(0, 1'b0);
    obs(4, 1'b0);
    wait_for(4, 1'b1, 60);
    ready_en <= 1'b1;
    wait_for(4, 1'b0, 100);
    // no synchro release, then switching never completes
    sync_release_in <= 1'b0;
    fault(1'b1);
    wait_for(1, 1'b1, (dead + 8) * 10);
    wait_for(4, 1'b1, 80);
    sync_release_in <= 1'b1;
    wait_for(4, 1'b0, 100);
    // manual close while idle
    manual_close_in <= 1'b1;
    ms(1);
    manual_close_in <= 1'b0;
    ms(1);
    obs(4, 1'b1);
    wait_for(4, 1'b0, 60);
    // not-ready settings and general block
    apb(1'b1, `ARC_ADDR_CTRL, 32'h0000_0002);
    ms(1);
    obs(4, 1'b1);
    apb(1'b1, `ARC_ADDR_CTRL, 32'h0000_0001);
    ms(1);
    obs(4, 1'b1);
    apb(1'b1, `ARC_ADDR_CTRL, 32'h0000_0003);
    general_block_in <= 1'b1;
    ms(1);
    obs(4, 1'b1);
    general_block_in <= 1'b0;
    ms(1);
    obs(4, 1'b0);
    // start without a trip
    protection_start_in <= 1'b1;
    wait_for(4, 1'b1, 150);
    protection_start_in <= 1'b0;
    wait_for(4, 1'b0, 100);
    // manual close in the dead time
    fault(1'b1);
    ms(1);
    manual_close_in <= 1'b1;
    ms(1);
    obs(4, 1'b1);
    manual_close_in <= 1'b0;
    wait_for(4, 1'b0, 150);
    // fault again in reclaim with one cycle enabled
    cw_q.push_back(3);
    fault(1'b1);
    wait_for(0, 1'b1, (dead + 4) * 10);
    wait_for(0, 1'b0, 60);
    fault(1'b1);
    wait_for(2, 1'b1, 100);
    wait_for(4, 1'b1, 100);
    ms(10);
    close_out();
  end
endmodule : arc_sequencer_tb
